// ==== verilog/sixteen_pin_io_port.sv ====
// Functional notes
// - Reset makes every pin an input
// - Direction word, one bit per pin, 1=output
// - Output latch word drives pins set output
// - Input pins keep latch value, pin undriven
// - Set-level forces output and loads level in the same write
// - Single direction and latch bits writable
// - Input word plus low and high halves
// - Watchdog floats pins and flags a stalled controller
// - Sleep wakes every 2.3 seconds
// - Pins float 18 ms then restore
// - End enters low power with glitch
// - Halt stops but keeps outputs driven
// - Finished device ignores all writes until reset
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

module sixteen_pin_io_port #(
  parameter int unsigned WAKE_CYCLES  = `WAKE_PERIOD_CYC,
  parameter int unsigned FLOAT_CYCLES = `FLOAT_TIME_CYC,
  parameter int unsigned WDT_CYCLES   = `WAKE_PERIOD_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [15:0]      rdata_out,
  input  wire logic [15:0] pin_in,
  output logic [15:0]      pin_out,
  output logic [15:0]      pin_oe_n_out
);

  // One-hot mask of the pin named in a single-pin write
  function automatic logic [15:0] pin_mask(
    input logic [3:0] idx
  );
    pin_mask = 16'h0001 << idx;
  endfunction : pin_mask

  gpio_port_pkg::reg_req_t    req;
  gpio_port_pkg::pin_ctrl_t   ctrl;
  gpio_port_pkg::port_state_t state_q;
  gpio_port_pkg::port_state_t return_q;

  logic [15:0] dir_q;
  logic [15:0] latch_q;
  logic [7:0]  sleep_left_q;
  logic        wdt_flag_q;
  logic        accept;
  logic        period_run;
  logic        period_fire;
  logic        float_fire;
  logic        kick;
  logic [15:0] sel_mask;
  logic        sel_val;
  logic [3:0]  cmd;
  logic [7:0]  sleep_req;

  // Bundle the register port
  assign req.addr  = addr_in;
  assign req.wdata = wdata_in;
  assign req.wr    = wr_in;
  assign req.rd    = rd_in;

  // Writes only land while the program runs
  assign accept   = req.wr && (state_q == gpio_port_pkg::ST_RUN);
  assign sel_mask = pin_mask(req.wdata[`PIN_IDX_MSB:0]);
  assign sel_val  = req.wdata[`PIN_VAL_POS];
  assign cmd      = req.wdata[`CMD_CODE_MSB:0];
  assign kick     = accept && (req.addr == `ADDR_COMMAND)
                    && (cmd == `CMD_KICK);

  // Zero sleep count still sleeps one period
  assign sleep_req = (req.wdata[`SLEEP_CNT_MSB:`SLEEP_CNT_LSB] == 8'h00)
                     ? 8'h01
                     : req.wdata[`SLEEP_CNT_MSB:`SLEEP_CNT_LSB];

  // One timer serves as watchdog while running, wake clock asleep
  assign period_run = ((state_q == gpio_port_pkg::ST_RUN) && !kick)
                      || (state_q == gpio_port_pkg::ST_SLEEP)
                      || (state_q == gpio_port_pkg::ST_END);

  interval_timer #(
    .CYCLES (WAKE_CYCLES)
  ) u_period (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (period_run),
    .fire_out (period_fire)
  );

  interval_timer #(
    .CYCLES (FLOAT_CYCLES)
  ) u_float (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (state_q == gpio_port_pkg::ST_FLOAT),
    .fire_out (float_fire)
  );

  // Direction word; whole, single bit and set-level writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_q <= `DIR_RESET;
    end else if (accept) begin
      case (req.addr)
        `ADDR_DIR_WORD: dir_q <= req.wdata;
        `ADDR_DIR_BIT: begin
          dir_q <= sel_val ? (dir_q | sel_mask)
                           : (dir_q & ~sel_mask);
        end
        `ADDR_SET_PIN: dir_q <= dir_q | sel_mask;
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Output latches; they store even while the pin is an input
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_q <= `OUT_RESET;
    end else if (accept) begin
      case (req.addr)
        `ADDR_OUT_WORD: latch_q <= req.wdata;
        `ADDR_OUT_LOW:  latch_q[7:0]  <= req.wdata[7:0];
        `ADDR_OUT_HIGH: latch_q[15:8] <= req.wdata[7:0];
        `ADDR_OUT_BIT, `ADDR_SET_PIN: begin
          latch_q <= sel_val ? (latch_q | sel_mask)
                             : (latch_q & ~sel_mask);
        end
        default: latch_q <= latch_q;
      endcase
    end
  end

  // Operating state; the float window follows every wake-up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q  <= gpio_port_pkg::ST_FLOAT;
      return_q <= gpio_port_pkg::ST_RUN;
    end else begin
      case (state_q)
        gpio_port_pkg::ST_RUN: begin
          if (period_fire) begin
            state_q  <= gpio_port_pkg::ST_FLOAT;
            return_q <= gpio_port_pkg::ST_RUN;
          end else if (accept && req.addr == `ADDR_COMMAND) begin
            case (cmd)
              `CMD_LONG_SLEEP,
              `CMD_SHORT_SLEEP: state_q <= gpio_port_pkg::ST_SLEEP;
              `CMD_END:  state_q <= gpio_port_pkg::ST_END;
              `CMD_HALT: state_q <= gpio_port_pkg::ST_HALT;
              default:   state_q <= gpio_port_pkg::ST_RUN;
            endcase
          end
        end
        gpio_port_pkg::ST_SLEEP: begin
          if (period_fire) begin
            state_q  <= gpio_port_pkg::ST_FLOAT;
            return_q <= (sleep_left_q == 8'h01)
                        ? gpio_port_pkg::ST_RUN
                        : gpio_port_pkg::ST_SLEEP;
          end
        end
        gpio_port_pkg::ST_END: begin
          // Low power never ends; it only glitches each period
          if (period_fire) begin
            state_q  <= gpio_port_pkg::ST_FLOAT;
            return_q <= gpio_port_pkg::ST_END;
          end
        end
        gpio_port_pkg::ST_FLOAT: begin
          if (float_fire) begin
            state_q <= return_q;
          end
        end
        gpio_port_pkg::ST_HALT: state_q <= gpio_port_pkg::ST_HALT;
        default: state_q <= gpio_port_pkg::ST_FLOAT;
      endcase
    end
  end

  // Remaining sleep periods
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sleep_left_q <= 8'h00;
    end else if (accept && req.addr == `ADDR_COMMAND) begin
      if (cmd == `CMD_LONG_SLEEP) begin
        sleep_left_q <= sleep_req;
      end else if (cmd == `CMD_SHORT_SLEEP) begin
        sleep_left_q <= 8'h01;
      end
    end else if (state_q == gpio_port_pkg::ST_SLEEP && period_fire) begin
      sleep_left_q <= sleep_left_q - 8'h01;
    end
  end

  // Sticky watchdog flag; a new bite wins over the clearing read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_flag_q <= 1'b0;
    end else if (state_q == gpio_port_pkg::ST_RUN && period_fire) begin
      wdt_flag_q <= 1'b1;
    end else if (req.rd && req.addr == `ADDR_STATUS) begin
      wdt_flag_q <= 1'b0;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        `ADDR_DIR_WORD: rdata_out <= dir_q;
        `ADDR_OUT_WORD: rdata_out <= latch_q;
        `ADDR_IN_WORD:  rdata_out <= pin_in;
        `ADDR_OUT_LOW:  rdata_out <= {8'h00, latch_q[7:0]};
        `ADDR_OUT_HIGH: rdata_out <= {8'h00, latch_q[15:8]};
        `ADDR_IN_LOW:   rdata_out <= {8'h00, pin_in[7:0]};
        `ADDR_IN_HIGH:  rdata_out <= {8'h00, pin_in[15:8]};
        `ADDR_STATUS: begin
          rdata_out <= {8'h00, sleep_left_q[3:0], wdt_flag_q,
                        3'(state_q)};
        end
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  // Pins: enable from direction, level from latch, all off in float
  assign ctrl.dir       = dir_q;
  assign ctrl.level     = latch_q;
  assign ctrl.float_all = (state_q == gpio_port_pkg::ST_FLOAT);

  pin_stage u_pins (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .ctrl_in      (ctrl),
    .pin_out      (pin_out),
    .pin_oe_n_out (pin_oe_n_out)
  );

  // Pins come out of reset undriven
  a_reset_all_inputs: assert property (
    @(posedge clk_in) $fell(rst_in) |-> (pin_oe_n_out == 16'hffff)
  ) else $error("pins driven right after reset");

  // Whole direction word write lands next cycle
  a_dir_word_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (accept && req.addr == `ADDR_DIR_WORD)
    |=> (dir_q == $past(req.wdata))
  ) else $error("direction word not stored");

  // Whole latch write lands even for input pins
  a_out_word_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (accept && req.addr == `ADDR_OUT_WORD)
    |=> (latch_q == $past(req.wdata))
  ) else $error("output word not stored");

  // Drivers follow direction and latch one cycle later
  a_drive_follows_dir: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q != gpio_port_pkg::ST_FLOAT)
    |=> (pin_oe_n_out == ~$past(dir_q))
        && (pin_out == $past(latch_q))
  ) else $error("pin drive does not follow registers");

  // Set-level makes the pin an output at the level
  a_set_pin_level: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (accept && req.addr == `ADDR_SET_PIN)
    |=> ((dir_q & $past(sel_mask)) == $past(sel_mask))
        && (((latch_q & $past(sel_mask)) != 16'h0000)
            == $past(sel_val))
  ) else $error("set-level did not force output");

  // Single direction bit leaves the other pins alone
  a_dir_bit_only: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (accept && req.addr == `ADDR_DIR_BIT)
    |=> ((dir_q & ~$past(sel_mask)) == ($past(dir_q) & ~$past(sel_mask)))
  ) else $error("single bit write disturbed others");

  // Input word read returns the sampled pins
  a_input_read: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (req.rd && req.addr == `ADDR_IN_WORD)
    |=> (rdata_out == $past(pin_in))
  ) else $error("input word read wrong");

  // Watchdog bite starts the float window
  a_wdt_bite: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_RUN && period_fire)
    |=> (state_q == gpio_port_pkg::ST_FLOAT) && wdt_flag_q
  ) else $error("watchdog bite missed");

  // Each sleep period ends in a wake-up
  a_sleep_wake: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_SLEEP && period_fire)
    |=> (state_q == gpio_port_pkg::ST_FLOAT)
  ) else $error("sleep did not wake");

  // Float window releases every driver
  a_float_inputs: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_FLOAT)
    |=> (pin_oe_n_out == 16'hffff)
  ) else $error("pin driven during float");

  // Ended device glitches and comes back to end
  a_end_glitch: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_END && period_fire)
    |=> (state_q == gpio_port_pkg::ST_FLOAT)
        && (return_q == gpio_port_pkg::ST_END)
  ) else $error("end state lost its wake-up");

  // Halt keeps drivers and ignores writes for good
  a_halt_holds: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_HALT)
    |=> (state_q == gpio_port_pkg::ST_HALT) && $stable(dir_q)
        && $stable(latch_q)
  ) else $error("halt state left or changed");

  // Ended device must not take register writes
  a_end_refuses: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_END && req.wr)
    |=> $stable(dir_q) && $stable(latch_q)
  ) else $error("write landed after end");

  // Float window hands back to the state it interrupted
  a_float_restores: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == gpio_port_pkg::ST_FLOAT && float_fire)
    |=> (state_q == $past(return_q))
  ) else $error("float window did not restore state");

endmodule : sixteen_pin_io_port

// ==== verilog/gpio_port_defines.svh ====
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Register offsets on the plain register port
`define ADDR_DIR_WORD    4'h0
`define ADDR_OUT_WORD    4'h1
`define ADDR_IN_WORD     4'h2
`define ADDR_OUT_LOW     4'h3
`define ADDR_OUT_HIGH    4'h4
`define ADDR_IN_LOW      4'h5
`define ADDR_IN_HIGH     4'h6
`define ADDR_DIR_BIT     4'h7
`define ADDR_OUT_BIT     4'h8
`define ADDR_SET_PIN     4'h9
`define ADDR_COMMAND     4'ha
`define ADDR_STATUS      4'hb

// Field positions of single-pin writes and commands
`define PIN_IDX_MSB      3
`define PIN_VAL_POS      4
`define CMD_CODE_MSB     3
`define SLEEP_CNT_LSB    8
`define SLEEP_CNT_MSB    15

// Command codes written to the command register
`define CMD_LONG_SLEEP   4'h1
`define CMD_SHORT_SLEEP  4'h2
`define CMD_END          4'h3
`define CMD_HALT         4'h4
`define CMD_KICK         4'h5

// Reset values
`define DIR_RESET        16'h0000
`define OUT_RESET        16'h0000

// Timing, times in their own units, counts derived at 100 MHz
`define CLK_MHZ          100
`define WAKE_PERIOD_MS   2300
`define FLOAT_TIME_MS    18
`define WAKE_PERIOD_CYC  (`WAKE_PERIOD_MS * 1000 * `CLK_MHZ)
`define FLOAT_TIME_CYC   (`FLOAT_TIME_MS * 1000 * `CLK_MHZ)

`endif

// ==== verilog/gpio_port_pkg.sv ====
package gpio_port_pkg;

  // Port operating states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_FLOAT,
    ST_SLEEP,
    ST_END,
    ST_HALT
  } port_state_t;

  // One register access as seen by the port
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // What the pin stage is asked to do
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] level;
    logic        float_all;
  } pin_ctrl_t;

endpackage : gpio_port_pkg

// ==== verilog/interval_timer.sv ====
`timescale 1ns/1ps

module interval_timer #(
  parameter int unsigned CYCLES = 32'd1000
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      fire_out
);

  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  logic [31:0] cnt_q;

  // Fires in the CYCLES-th cycle of an unbroken run
  assign fire_out = run_in && (cnt_q == LAST);

  // Dropping run restarts the interval from zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0000_0000;
    end else if (!run_in || fire_out) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

endmodule : interval_timer

// ==== verilog/pin_stage.sv ====
`timescale 1ns/1ps

module pin_stage (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire gpio_port_pkg::pin_ctrl_t ctrl_in,
  output logic [15:0]                  pin_out,
  output logic [15:0]                  pin_oe_n_out
);

  // One registered driver per pin; enable is low while driving
  for (genvar i = 0; i < 16; i++) begin : g_pin
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        pin_out[i]      <= 1'b0;
        pin_oe_n_out[i] <= 1'b1;
      end else begin
        pin_out[i]      <= ctrl_in.level[i];
        pin_oe_n_out[i] <= ~(ctrl_in.dir[i] & ~ctrl_in.float_all);
      end
    end
  end

endmodule : pin_stage

// ==== dv/pin_partner.sv ====
`timescale 1ns/1ps

module pin_partner (
  input  wire logic [15:0] drive_in,
  input  wire logic [15:0] oe_n_in,
  input  wire logic [15:0] ext_level_in,
  input  wire logic [15:0] ext_en_in,
  output logic [15:0]      level_out
);
  // Pin wins when driven, else outside source, else pull-up
  // Pull-up avoids a stale level once the port lets go
  assign level_out = (~oe_n_in & drive_in)
                   | (oe_n_in & ext_en_in & ext_level_in)
                   | (oe_n_in & ~ext_en_in);
endmodule : pin_partner

// ==== dv/sixteen_pin_io_port_tb_top.sv ====
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

module sixteen_pin_io_port_tb_top;
  localparam int WAKE = 400;
  localparam int FLT  = 10;
  logic        clk_in;
  logic        rst_in;
  logic [3:0]  addr_in;
  logic [15:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [15:0] rdata_out;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe_n_out;
  logic [15:0] ext_level;
  logic [15:0] ext_en;
  logic [15:0] v;
  int          err_count;
  int          checks_done;
  int          n;

  sixteen_pin_io_port #(
    .WAKE_CYCLES (WAKE),
    .FLOAT_CYCLES(FLT),
    .WDT_CYCLES  (WAKE)
  ) u_sixteen_pin_io_port (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .addr_in     (addr_in),
    .wdata_in    (wdata_in),
    .wr_in       (wr_in),
    .rd_in       (rd_in),
    .rdata_out   (rdata_out),
    .pin_in      (pin_in),
    .pin_out     (pin_out),
    .pin_oe_n_out(pin_oe_n_out)
  );

  pin_partner u_pin_partner (
    .drive_in    (pin_out),
    .oe_n_in     (pin_oe_n_out),
    .ext_level_in(ext_level),
    .ext_en_in   (ext_en),
    .level_out   (pin_in)
  );

  // Free-running system clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr_reg

  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask : rd_reg

  task automatic wait_run();
    int i;
    v = 16'hffff;
    for (i = 0; i < 200 && v[2:0] !== 3'h0; i++) begin
      rd_reg(`ADDR_STATUS, v);
    end
  endtask : wait_run

  // Cycles until every pin lets go, bounded
  task automatic wait_float(output int c);
    c = 0;
    while (pin_oe_n_out !== 16'hffff && c < 2000) begin
      @(posedge clk_in);
      #1 c++;
    end
  endtask : wait_float

  task automatic float_len(output int c);
    c = 0;
    while (pin_oe_n_out === 16'hffff && c < 200) begin
      @(posedge clk_in);
      #1 c++;
    end
  endtask : float_len

  task automatic do_reset();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check("oe_n after reset", pin_oe_n_out, 16'hffff);
    wait_run();
    rd_reg(`ADDR_DIR_WORD, v);
    check("dir after reset", v, 16'h0000);
  endtask : do_reset

  task automatic kick();
    wr_reg(`ADDR_COMMAND, {12'h000, `CMD_KICK});
  endtask : kick

  task automatic t_dir_out();
    kick();
    wr_reg(`ADDR_OUT_WORD, 16'ha5c3);
    repeat (2) @(posedge clk_in);
    #1 check("oe_n input pins", pin_oe_n_out, 16'hffff);
    rd_reg(`ADDR_OUT_WORD, v);
    check("latch word", v, 16'ha5c3);
    wr_reg(`ADDR_DIR_WORD, 16'h002e);
    repeat (2) @(posedge clk_in);
    #1 check("oe_n", pin_oe_n_out, 16'hffd1);
    check("drive", pin_out & 16'h002e, 16'h0002);
    rd_reg(`ADDR_IN_WORD, v);
    check("in word", v, 16'hffd3);
  endtask : t_dir_out

  task automatic t_bits();
    kick();
    wr_reg(`ADDR_DIR_BIT, 16'h001f);
    wr_reg(`ADDR_OUT_BIT, 16'h0000);
    wr_reg(`ADDR_SET_PIN, 16'h0014);
    rd_reg(`ADDR_DIR_WORD, v);
    check("dir bits", v, 16'h803e);
    rd_reg(`ADDR_OUT_WORD, v);
    check("latch bits", v, 16'ha5d2);
  endtask : t_bits

  task automatic t_halves();
    kick();
    wr_reg(`ADDR_DIR_WORD, 16'h0000);
    ext_en    <= 16'hffff;
    ext_level <= 16'h3c96;
    wr_reg(`ADDR_OUT_LOW, 16'h5577);
    wr_reg(`ADDR_OUT_HIGH, 16'h6688);
    rd_reg(`ADDR_OUT_WORD, v);
    check("out halves", v, 16'h8877);
    rd_reg(`ADDR_IN_LOW, v);
    check("in low", v, 16'h0096);
    rd_reg(`ADDR_IN_HIGH, v);
    check("in high", v, 16'h003c);
    rd_reg(`ADDR_IN_WORD, v);
    check("in word ext", v, 16'h3c96);
    ext_en <= 16'h0000;
  endtask : t_halves

  // Sleep wake-up: pins float, then come back as they were
  task automatic t_sleep();
    kick();
    wr_reg(`ADDR_DIR_WORD, 16'h00ff);
    wr_reg(`ADDR_COMMAND, {12'h000, `CMD_SHORT_SLEEP});
    wait_float(n);
    v = 16'(n >= WAKE - 10 && n <= WAKE + 10);
    check("wake period", v, 16'h1);
    float_len(n);
    check("float length", 16'(n), 16'(FLT));
    check("restored oe_n", pin_oe_n_out, 16'hff00);
    wait_run();
    // Two-period long sleep wakes once back into sleep, then runs
    kick();
    wr_reg(`ADDR_COMMAND, {8'h02, 4'h0, `CMD_LONG_SLEEP});
    wait_float(n);
    v = 16'(n >= WAKE - 10 && n <= WAKE + 10);
    check("long wake 1", v, 16'h1);
    float_len(n);
    check("long float 1", 16'(n), 16'(FLT));
    rd_reg(`ADDR_STATUS, v);
    check("long back asleep", v & 16'h00f7, 16'h0012);
    wait_float(n);
    v = 16'(n >= WAKE - 10 && n <= WAKE + 10);
    check("long wake 2", v, 16'h1);
    float_len(n);
    check("long restored", pin_oe_n_out, 16'hff00);
    wait_run();
  endtask : t_sleep

  task automatic t_wdog();
    kick();
    wait_float(n);
    v = 16'(n >= WAKE - 10 && n <= WAKE + 10);
    check("bite time", v, 16'h1);
    rd_reg(`ADDR_STATUS, v);
    check("bite flag", {15'h0, v[3]}, 16'h1);
    wait_run();
    rd_reg(`ADDR_DIR_WORD, v);
    check("dir kept", v, 16'h00ff);
  endtask : t_wdog

  task automatic t_end();
    kick();
    wr_reg(`ADDR_COMMAND, {12'h000, `CMD_END});
    wr_reg(`ADDR_DIR_WORD, 16'hffff);
    rd_reg(`ADDR_DIR_WORD, v);
    check("end refuses", v, 16'h00ff);
    wait_float(n);
    check("end glitch", 16'(n < 2000), 16'h1);
    float_len(n);
    rd_reg(`ADDR_STATUS, v);
    check("end state", {13'h0, v[2:0]}, 16'h3);
    do_reset();
  endtask : t_end

  // Halt must never let the pins float
  task automatic t_halt();
    int i;
    kick();
    wr_reg(`ADDR_DIR_WORD, 16'h0f0f);
    wr_reg(`ADDR_COMMAND, {12'h000, `CMD_HALT});
    n = 0;
    for (i = 0; i < 2 * WAKE + 2 * FLT; i++) begin
      @(posedge clk_in);
      #1 if (pin_oe_n_out !== 16'hf0f0) n++;
    end
    check("halt glitches", 16'(n), 16'h0);
    wr_reg(`ADDR_DIR_WORD, 16'h0000);
    rd_reg(`ADDR_DIR_WORD, v);
    check("halt refuses", v, 16'h0f0f);
    do_reset();
  endtask : t_halt

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    err_count   = 0;
    checks_done = 0;
    // Held from time zero so no edge sees unreset state
    rst_in      = 1'b1;
    addr_in     = 4'h0;
    wdata_in    = 16'h0000;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    ext_level   = 16'h0000;
    ext_en      = 16'h0000;
    do_reset();
    t_dir_out();
    t_bits();
    t_halves();
    t_sleep();
    t_wdog();
    t_end();
    t_halt();
    summarize();
  end

  // Run needs about 3000 cycles; cut a hang well beyond that
  initial begin
    #200000;
    err_count++;
    summarize();
  end
endmodule : sixteen_pin_io_port_tb_top
